/* logic/ipmx_top.sv */
// input port mux and serial data inversion, apb register slave
// assumes pins arrive asynchronously; serial engine and gpio share pclk
//
// Chosen here: the APB register port.
`timescale 1ns/1ns
`default_nettype none
module ipmx_top (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        clk_en,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [3:0]  port_pin,
	output logic      [3:0]  analog_pin_en,
	output logic             irq_one_level,
	input  wire logic        serial_rx_pin,
	output logic             rx_data,
	input  wire logic        tx_data,
	input  wire logic        gpio_out,
	input  wire logic        gpio_oe,
	output logic             serial_tx_pin,
	output logic             serial_tx_oe,
	output logic             tx_pin_select
);
	// all state of the block in one record
	typedef struct packed {
		logic        tx_pin_select; // shared pin drives transmit
		logic        tx_invert;     // transmit data inverted
		logic        rx_invert;     // receive data inverted
		logic        irq_select;    // pin three as interrupt
		logic [3:0]  channel;       // converter channel field
		logic [3:0]  pin_s1;        // port pin sync stage one
		logic [3:0]  pin_s2;        // port pin sync stage two
		logic        rx_s1;         // receive pin sync stage one
		logic        rx_s2;         // receive pin sync stage two
		logic [3:0]  analog_en;     // registered converter claim
		logic        irq_level;     // registered interrupt level
		logic [31:0] rdata;         // read data holding register
		logic        ready;         // access answer
		logic        err;           // unmapped address answer
	} ipmx_state_t;

	ipmx_state_t cur;   // registered state
	ipmx_state_t next;  // next state

	ipmx_route_if rt ();  // link to the pin router

	// selects and synchronised pins out to the router
	assign rt.pin_level  = cur.pin_s2;
	assign rt.channel    = cur.channel;
	assign rt.irq_select = cur.irq_select;

	ipmx_pin_route i_ipmx_pin_route (
		.rt (rt)
	);

	// top bit past the register index within a byte address
	localparam int IPMX_IDX_END = ipmx_pkg::IPMX_IDX_LSB + 16;

	// index decode of a byte address, unaligned ones never match
	function automatic logic ipmx_hit(input logic [31:0] a, input logic [15:0] idx);
		ipmx_hit = (a[1:0] == 2'b00) &&
			(a[31:IPMX_IDX_END] == '0) &&
			(a[IPMX_IDX_END-1:ipmx_pkg::IPMX_IDX_LSB] == idx);
	endfunction

	// serial pin control as read back
	function automatic logic [7:0] ipmx_spc_view(input ipmx_state_t s);
		logic [7:0] v;
		v = '0;
		v = v | ipmx_pkg::IPMX_SPC_FIXED;
		v[ipmx_pkg::IPMX_SPC_TPS] = s.tx_pin_select;
		v[ipmx_pkg::IPMX_SPC_TXI] = s.tx_invert;
		v[ipmx_pkg::IPMX_SPC_RXI] = s.rx_invert;
		ipmx_spc_view = v;
	endfunction

	// mode register as read back
	function automatic logic [7:0] ipmx_pmr_view(input ipmx_state_t s);
		logic [7:0] v;
		v = ipmx_pkg::IPMX_PMR_RST;
		v[ipmx_pkg::IPMX_PMR_IRQ] = s.irq_select;
		ipmx_pmr_view = v;
	endfunction

	logic access;     // access phase cycle before the answer
	logic commit;     // edge at which the transfer completes
	logic hit_spc;    // serial pin control selected
	logic hit_pdr;    // port data selected
	logic hit_pmr;    // port mode selected
	logic hit_conv;   // converter channel selected
	logic mapped;     // any register selected

	assign access   = psel && penable && !cur.ready;
	assign commit   = psel && penable && cur.ready;
	assign hit_spc  = ipmx_hit(paddr, ipmx_pkg::IPMX_SPC_IDX);
	assign hit_pdr  = ipmx_hit(paddr, ipmx_pkg::IPMX_PDR_IDX);
	assign hit_pmr  = ipmx_hit(paddr, ipmx_pkg::IPMX_PMR_IDX);
	assign hit_conv = ipmx_hit(paddr, ipmx_pkg::IPMX_CONV_IDX);
	assign mapped   = hit_spc | hit_pdr | hit_pmr | hit_conv;

	// next state: sync, apb answer, register writes
	always_comb begin
		next = cur;
		// pins go through two flops before anything reads them
		next.pin_s1 = port_pin;
		next.pin_s2 = cur.pin_s1;
		next.rx_s1  = serial_rx_pin;
		next.rx_s2  = cur.rx_s1;
		// router results are registered so outputs come from flops
		next.analog_en = rt.analog_en;
		next.irq_level = rt.irq_level;
		// answer one cycle into the access phase, dropped after commit
		next.ready = access;
		next.err   = access && !mapped;
		if (access && !pwrite) begin
			// read data captured the cycle before it is taken
			next.rdata = '0;
			if (hit_spc) begin
				next.rdata[7:0] = ipmx_spc_view(cur);
			end else if (hit_pmr) begin
				next.rdata[7:0] = ipmx_pmr_view(cur);
			end else if (hit_pdr) begin
				next.rdata[3:0] = rt.read_value;
			end else if (hit_conv) begin
				next.rdata[3:0] = cur.channel;
			end else begin
				next.rdata = '0;
			end
		end
		if (commit && pwrite && pstrb[0]) begin
			// writes act on the completing edge only
			if (hit_spc) begin
				next.tx_pin_select = pwdata[ipmx_pkg::IPMX_SPC_TPS];
				next.tx_invert = pwdata[ipmx_pkg::IPMX_SPC_TXI];
				next.rx_invert = pwdata[ipmx_pkg::IPMX_SPC_RXI];
			end else if (hit_pmr) begin
				next.irq_select = pwdata[ipmx_pkg::IPMX_PMR_IRQ];
			end else if (hit_conv) begin
				next.channel = pwdata[3:0];
			end else begin
				// data register and unmapped: writes ignored
				next.channel = cur.channel;
			end
		end
		if (!clk_en) begin
			// clock enable low freezes every flop
			next = cur;
		end
	end

	// reset values of the whole record
	localparam ipmx_state_t IPMX_RST_STATE = '{
		tx_pin_select: 1'b0,
		tx_invert:     1'b0,
		rx_invert:     1'b0,
		irq_select:    ipmx_pkg::IPMX_PMR_RST[ipmx_pkg::IPMX_PMR_IRQ],
		channel:       ipmx_pkg::IPMX_CH_RST,
		pin_s1:        4'h0,
		pin_s2:        4'h0,
		rx_s1:         1'b0,
		rx_s2:         1'b0,
		analog_en:     4'h0,
		irq_level:     1'b0,
		rdata:         32'h0000_0000,
		ready:         1'b0,
		err:           1'b0
	};

	// state register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cur <= IPMX_RST_STATE;
		end else begin
			cur <= next;
		end
	end

	// bus answer straight from flops
	assign prdata        = cur.rdata;
	assign pready        = cur.ready;
	assign pslverr       = cur.err;
	assign analog_pin_en = cur.analog_en;
	assign irq_one_level = cur.irq_level;
	assign tx_pin_select = cur.tx_pin_select;

	// the inversion xors stay combinational so they add no delay to a bit edge;
	// the price is that an inversion change glitches data in flight
	// receive xor path
	assign rx_data = cur.rx_s2 ^ cur.rx_invert;

	// shared pin: gpio unless routed to the transmitter
	// transmit xor path
	assign serial_tx_pin = cur.tx_pin_select ? (tx_data ^ cur.tx_invert) : gpio_out;
	assign serial_tx_oe  = cur.tx_pin_select ? 1'b1 : gpio_oe;
endmodule
`default_nettype wire

/* common/ipmx_pkg.sv */
// constants for the input port mux and serial data inversion block
// assumes a 32-bit apb slave on pclk; byte address is four times the index
// Notes on behaviour
// - pin three: irq select, else channel 0111
// - pins two..zero analog on 0110/0101/0100
// - serial control bits 7,6 read one
// - bit 5 routes shared pin to transmit
// - bit 3 inverts transmit pin data
// - bit 2 inverts received pin data
// - reset clears select and both inversions
// - inversion change acts right after write
// - data read shows pins, analog ones zero
// - mode register resets F7, bit 3 selectable
package ipmx_pkg;
	// register indices as printed; byte address is index times four
	localparam logic [15:0] IPMX_SPC_IDX   = 16'hFF91;
	localparam logic [15:0] IPMX_PDR_IDX   = 16'hFFDE;
	localparam logic [15:0] IPMX_PMR_IDX   = 16'hFFEE;
	localparam logic [15:0] IPMX_CONV_IDX  = 16'hFF00;
	localparam int          IPMX_ADDR_W    = 18;
	localparam int          IPMX_IDX_LSB   = 2;
	// serial pin control field positions
	localparam int          IPMX_SPC_TPS   = 5;
	localparam int          IPMX_SPC_TXI   = 3;
	localparam int          IPMX_SPC_RXI   = 2;
	localparam logic [7:0]  IPMX_SPC_FIXED = 8'hC0;
	// mode register layout
	localparam int          IPMX_PMR_IRQ   = 3;
	localparam logic [7:0]  IPMX_PMR_RST   = 8'hF7;
	// channel codes that claim port pins 0..3
	localparam logic [3:0]  IPMX_CH_PIN0   = 4'h4;
	localparam logic [3:0]  IPMX_CH_PIN1   = 4'h5;
	localparam logic [3:0]  IPMX_CH_PIN2   = 4'h6;
	localparam logic [3:0]  IPMX_CH_PIN3   = 4'h7;
	localparam logic [3:0]  IPMX_CH_RST    = 4'h0;
	localparam int          IPMX_PINS      = 4;
endpackage

/* common/ipmx_route_if.sv */
// carrier between the register top and the port pin router
// assumes both ends sit on the same pclk domain
`timescale 1ns/1ns
`default_nettype none
interface ipmx_route_if;
	logic [3:0] pin_level;   // synchronised port pin levels
	logic [3:0] channel;     // converter channel field
	logic       irq_select;  // pin three as interrupt input
	logic [3:0] read_value;  // data register read value
	logic [3:0] analog_en;   // pins handed to the converter
	logic       irq_level;   // interrupt input level
	modport regs  (output pin_level, output channel, output irq_select,
		input read_value, input analog_en, input irq_level);
	modport route (input pin_level, input channel, input irq_select,
		output read_value, output analog_en, output irq_level);
endinterface
`default_nettype wire

/* logic/ipmx_pin_route.sv */
// port pin function router: analog, interrupt or plain input per pin
// assumes synchronised pin levels and registered selects from the top
`timescale 1ns/1ns
`default_nettype none
module ipmx_pin_route (
	ipmx_route_if.route rt
);
	// code that claims pin n for the converter
	function automatic logic [3:0] ipmx_pin_code(input int n);
		case (n)
			0:       ipmx_pin_code = ipmx_pkg::IPMX_CH_PIN0;
			1:       ipmx_pin_code = ipmx_pkg::IPMX_CH_PIN1;
			2:       ipmx_pin_code = ipmx_pkg::IPMX_CH_PIN2;
			default: ipmx_pin_code = ipmx_pkg::IPMX_CH_PIN3;
		endcase
	endfunction

	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_low
			assign rt.analog_en[g] = (rt.channel == ipmx_pin_code(g));
		end
	endgenerate

	assign rt.analog_en[3] = !rt.irq_select && (rt.channel == ipmx_pin_code(3));
	assign rt.irq_level    = rt.irq_select & rt.pin_level[3];

	assign rt.read_value = rt.pin_level & ~rt.analog_en;
endmodule
`default_nettype wire

/* tb/ipmx_partner.sv */
// board side of the block: pin levels for the input port and the serial receive line
// assumes the bench hands the wanted levels on pclk; pins move one edge later
`timescale 1ns/1ns
`default_nettype none
module ipmx_partner (
	input  wire logic       pclk,
	input  wire logic [4:0] want,
	output logic      [3:0] port_pin,
	output logic            serial_rx_pin
);
	// input-only pins are always driven by the board, so no released state exists;
	// levels are unknown only before the first edge, which falls inside reset
	// levels change just after a rising edge, unrelated to any register access
	always @(posedge pclk) begin
		{serial_rx_pin, port_pin} <= want;
	end
endmodule
`default_nettype wire

/* tb/ipmx_assertions.sv */
// port-level checker for the pin mux and serial inversion block
// assumes it is bound into ipmx_top and that clk_en stays high
`timescale 1ns/1ns
`default_nettype none
module ipmx_assertions (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0]  pstrb,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [3:0]  analog_pin_en,
	input wire logic        irq_one_level,
	input wire logic        tx_data,
	input wire logic        gpio_out,
	input wire logic        serial_tx_pin,
	input wire logic        serial_tx_oe,
	input wire logic        tx_pin_select
);
	localparam logic [31:0] A_SPC = {14'h0000, ipmx_pkg::IPMX_SPC_IDX, 2'h0};
	localparam logic [31:0] A_PDR = {14'h0000, ipmx_pkg::IPMX_PDR_IDX, 2'h0};
	localparam logic [31:0] A_PMR = {14'h0000, ipmx_pkg::IPMX_PMR_IDX, 2'h0};
	localparam logic [31:0] A_CH  = {14'h0000, ipmx_pkg::IPMX_CONV_IDX, 2'h0};
	logic h_sel, h_txi, h_rxi; // shadow of the serial control bits
	wire logic wr_spc = psel && penable && pready && pwrite && pstrb[0] && paddr == A_SPC;
	wire logic mapped = paddr inside {A_SPC, A_PDR, A_PMR, A_CH};
	// shadow follows accepted writes only, so a refused write cannot move it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{h_sel, h_txi, h_rxi} <= 3'h0;
		end else if (wr_spc) begin
			{h_sel, h_txi, h_rxi} <= {pwdata[5], pwdata[3], pwdata[2]};
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_access; psel && penable && !pready; endsequence
	sequence s_rd_spc; pready && !pwrite && paddr == A_SPC; endsequence
	chk_ready_wait: assert property (s_access |=> pready) else $error("no answer");
	chk_ready_pulse: assert property (pready |=> !pready) else $error("pready held");
	chk_err_map: assert property (pready |-> pslverr == !mapped) else $error("bad pslverr");
	chk_spc_read: assert property (s_rd_spc |->
		prdata[7:0] == {2'h3, h_sel, 1'b0, h_txi, h_rxi, 2'h0}) else $error("spc read");
	chk_sel_copy: assert property (wr_spc |=> tx_pin_select == $past(pwdata[5]))
		else $error("select copy");
	chk_tx_route: assert property (tx_pin_select |->
		serial_tx_oe && serial_tx_pin == (tx_data ^ h_txi)) else $error("tx path");
	chk_gpio_route: assert property (!tx_pin_select |-> serial_tx_pin == gpio_out)
		else $error("gpio path");
	chk_irq_excl: assert property (irq_one_level |-> !analog_pin_en[3]) else $error("irq");
	chk_one_chan: assert property ($onehot0(analog_pin_en)) else $error("channels");
endmodule
bind ipmx_top ipmx_assertions i_ipmx_assertions (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .analog_pin_en(analog_pin_en), .irq_one_level(irq_one_level),
	.tx_data(tx_data), .gpio_out(gpio_out), .serial_tx_pin(serial_tx_pin),
	.serial_tx_oe(serial_tx_oe), .tx_pin_select(tx_pin_select)
);
`default_nettype wire

/* tb/ipmx_top_tb.sv */
// self-checking bench: apb master, board partner, queue-fed response monitor
// assumes pclk 20 MHz; clk_en stays high except for one short freeze
`timescale 1ns/1ns
`default_nettype none
module ipmx_top_tb;
	localparam logic [31:0] A_SPC = {14'h0000, ipmx_pkg::IPMX_SPC_IDX, 2'h0};
	localparam logic [31:0] A_PDR = {14'h0000, ipmx_pkg::IPMX_PDR_IDX, 2'h0};
	localparam logic [31:0] A_PMR = {14'h0000, ipmx_pkg::IPMX_PMR_IDX, 2'h0};
	localparam logic [31:0] A_CH  = {14'h0000, ipmx_pkg::IPMX_CONV_IDX, 2'h0};
	logic        pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr;
	logic [31:0] paddr, pwdata, prdata, seed;
	logic [3:0]  pstrb, port_pin, analog_pin_en, mask, ch;
	logic        irq_one_level, serial_rx_pin, rx_data, tx_data, gpio_out, gpio_oe;
	logic        serial_tx_pin, serial_tx_oe, tx_pin_select, irq, sel, inv;
	logic [4:0]  want;   // levels the board partner puts on the pins
	logic [33:0] q[$];   // expected {is_read, error, data} per transfer
	logic [33:0] e;
	int          n_mismatch, total_checks, i;
	ipmx_top i_ipmx_top (
		.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .port_pin(port_pin),
		.analog_pin_en(analog_pin_en), .irq_one_level(irq_one_level),
		.serial_rx_pin(serial_rx_pin), .rx_data(rx_data), .tx_data(tx_data),
		.gpio_out(gpio_out), .gpio_oe(gpio_oe), .serial_tx_pin(serial_tx_pin),
		.serial_tx_oe(serial_tx_oe), .tx_pin_select(tx_pin_select)
	);
	ipmx_partner i_ipmx_partner (
		.pclk(pclk), .want(want), .port_pin(port_pin), .serial_rx_pin(serial_rx_pin)
	);
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
		total_checks++;
		if (g !== x) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", nm, x, g);
		end
	endtask
	// one transfer; entered just after a rising edge, leaves one idle cycle after
	task automatic apb(input logic w, input logic [31:0] a, d, input logic [33:0] x);
		q.push_back(x);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// pready is judged at rising edges only; the edge that sees it high completes
		do @(posedge pclk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic rd(input logic [31:0] a, x);
		apb(1'b0, a, 32'h0, {2'h2, x});
	endtask
	task automatic wr(input logic [31:0] a, d);
		apb(1'b1, a, d, 34'h0);
	endtask
	// monitor: every answer takes the oldest note; data compared on reads only
	always @(negedge pclk) begin
		if (pready === 1'b1) begin
			e = q.pop_front();
			chk("pslverr", {31'h0, e[32]}, {31'h0, pslverr});
			if (e[33]) chk("prdata", e[31:0], prdata);
		end
	end
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// the whole sequence needs about 650 cycles; some thirty times that marks a hang
	initial begin
		repeat (20000) @(posedge pclk);
		n_mismatch++;
		wrap_up;
	end
	initial begin
		{presetn, psel, penable, pwrite, tx_data, gpio_out, gpio_oe} = 7'h00;
		{paddr, pwdata, want, clk_en, pstrb} = {64'h0, 5'h00, 1'b1, 4'hF};
		{n_mismatch, total_checks, seed} = {32'h0, 32'h0, 32'h595AA381};
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(A_SPC, 32'hC0);
		rd(A_PMR, 32'hF7);
		apb(1'b0, A_CH + 32'h4, 32'h0, {2'h3, 32'h0});
		// select first, inversions after, reserved bits left zero
		wr(A_SPC, 32'h20);
		wr(A_SPC, 32'h2C);
		rd(A_SPC, 32'hEC);
		wr(A_PMR, 32'h00);
		rd(A_PMR, 32'hF7);
		// every channel code with and without pin three as interrupt input
		for (i = 0; i < 32; i++) begin
			{irq, ch} = i[4:0];
			seed = lfsr(seed);
			want <= seed[4:0];
			wr(A_CH, {28'h0, ch});
			wr(A_PMR, {28'h0, irq, 3'h0});
			repeat (5) @(posedge pclk);
			mask = {ch == ipmx_pkg::IPMX_CH_PIN3 && !irq, ch == ipmx_pkg::IPMX_CH_PIN2,
				ch == ipmx_pkg::IPMX_CH_PIN1, ch == ipmx_pkg::IPMX_CH_PIN0};
			rd(A_PDR, {28'h0, want[3:0] & ~mask});
			chk("analog_pin_en", {28'h0, mask}, {28'h0, analog_pin_en});
			chk("irq_one_level", {31'h0, irq & want[3]}, {31'h0, irq_one_level});
			chk("rx_data", {31'h0, ~want[4]}, {31'h0, rx_data});
		end
		rd(A_PMR, 32'hFF);
		// clock enable low: the receive sync must keep its old level
		clk_en <= 1'b0;
		want <= {~want[4], want[3:0]};
		repeat (5) @(posedge pclk);
		chk("rx_data", {31'h0, want[4]}, {31'h0, rx_data});
		clk_en <= 1'b1;
		repeat (3) @(posedge pclk);
		chk("rx_data", {31'h0, ~want[4]}, {31'h0, rx_data});
		// transmit path: inverted, plain, then handed back to the gpio logic
		for (i = 0; i < 24; i++) begin
			if (i == 8) wr(A_SPC, 32'h20);
			if (i == 16) wr(A_SPC, 32'h00);
			{sel, inv} = {i < 16, i < 8};
			seed = lfsr(seed);
			{gpio_oe, gpio_out, tx_data} <= seed[2:0];
			@(negedge pclk);
			chk("serial_tx_pin", {31'h0, sel ? seed[0] ^ inv : seed[1]}, {31'h0, serial_tx_pin});
			chk("serial_tx_oe", {31'h0, sel | seed[2]}, {31'h0, serial_tx_oe});
			chk("rx_data", {31'h0, want[4] ^ inv}, {31'h0, rx_data});
			chk("tx_pin_select", {31'h0, sel}, {31'h0, tx_pin_select});
			@(posedge pclk);
		end
		wr(A_SPC, 32'h2C);
		// low byte lane off, then an unmapped word: neither may change anything
		pstrb <= 4'h0;
		wr(A_SPC, 32'h00);
		pstrb <= 4'hF;
		apb(1'b1, A_CH + 32'h4, 32'h0000000F, {2'h1, 32'h0});
		rd(A_SPC, 32'hEC);
		presetn <= 1'b0;
		@(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk("tx_pin_select", 32'h0, {31'h0, tx_pin_select});
		rd(A_SPC, 32'hC0);
		wrap_up;
	end
endmodule
`default_nettype wire
